/* File: rmf_pkg.sv */
// rmf_pkg: constants and types for the radio mode and function control block
// assumes: core clock at 250 MHz; imported by rmf_decode, rmf_gap_timer and rmf_ctrl
package rmf_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam logic [7:0] MODE_ADDR = 8'hc1;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] FPA_LO_DEF = 16'h00d7;
	localparam logic [15:0] FPA_HI_DEF = 16'h00c4;
	localparam logic [15:0] FPB_LO_DEF = 16'h0033;
	localparam logic [15:0] FPB_HI_DEF = 16'h00b4;
	localparam logic [15:0] LIM_DEF = 16'h3fff;
	localparam logic [15:0] PROG_CLR = 16'h0000;
	// field positions of the mode word
	localparam int unsigned ST_LO = 0;
	localparam int unsigned MOD_LO = 3;
	localparam int unsigned PAT_B_BIT = 5;
	localparam int unsigned PAT_A_BIT = 6;
	localparam int unsigned PAT_AI_BIT = 7;
	localparam int unsigned SUB_INV_BIT = 9;
	localparam int unsigned SUB_DCS_BIT = 10;
	localparam int unsigned SUB_TSQ_BIT = 11;
	localparam int unsigned TONE_BIT = 12;
	localparam int unsigned IB_LO = 13;
	localparam int unsigned VOICE_BIT = 15;
	// power control word bits
	localparam int unsigned PWR_SP_BIT = 5;
	localparam int unsigned PWR_KEEP_BIT = 4;
	// resync gap
	localparam int unsigned GAP_US = 350;
	localparam int unsigned GAP_CYC = GAP_US * CLK_MHZ;
	typedef enum logic [1:0] {
		RMF_IDLE = 2'b00,
		RMF_RX = 2'b01,
		RMF_TX = 2'b10,
		RMF_RSV = 2'b11
	} rmf_state_e;
endpackage

/* File: rmf_en_if.sv */
// rmf_en_if: decoded function enables between decoder and main block
// assumes: single clock domain, driven combinationally from the mode word
`timescale 1ns/1ns
`default_nettype none
interface rmf_en_if;
	logic rx;
	logic tx;
	logic [1:0] modem;
	logic [2:0] pat;
	logic [2:0] sub;
	logic tone;
	logic [1:0] inband;
	logic voice;
	modport src (output rx, tx, modem, pat, sub, tone, inband, voice);
	modport dst (input rx, tx, modem, pat, sub, tone, inband, voice);
endinterface
`default_nettype wire

/* File: rmf_decode.sv */
// rmf_decode: splits the mode word into raw function enables
// assumes: mode word is registered upstream
`timescale 1ns/1ns
`default_nettype none
module rmf_decode
	import rmf_pkg::*;
(
	input wire logic [15:0] mode,
	rmf_en_if.src en
);
	rmf_state_e st;
	// state field, reserved code treated as idle
	always_comb
	begin
		st = rmf_state_e'(mode[ST_LO+:2]);
		en.rx = (st == RMF_RX);
		en.tx = (st == RMF_TX);
		en.modem = mode[MOD_LO+:2];
		en.pat = {mode[PAT_AI_BIT], mode[PAT_A_BIT], mode[PAT_B_BIT]};
		en.sub = {mode[SUB_TSQ_BIT], mode[SUB_DCS_BIT], mode[SUB_INV_BIT]};
		en.tone = mode[TONE_BIT];
		en.inband = mode[IB_LO+:2];
		en.voice = mode[VOICE_BIT];
	end
endmodule // rmf_decode
`default_nettype wire

/* File: rmf_gap_timer.sv */
// rmf_gap_timer: counts the quiet time after a resync request
// assumes: hold is a level from logic on core_clk
`timescale 1ns/1ns
`default_nettype none
module rmf_gap_timer
	import rmf_pkg::*;
#(
	parameter int unsigned CYC = GAP_CYC
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hold,
	output logic done
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	// counts while held, saturates once the gap has elapsed
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (!hold)
			cnt_nxt = 32'h0000_0000;
		else if (cnt_r < CYC)
			cnt_nxt = cnt_r + 32'h0000_0001;
		done = (cnt_r >= CYC);
	end
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
			cnt_r <= 32'h0000_0000;
		else
			cnt_r <= cnt_nxt;
	end
endmodule // rmf_gap_timer
`default_nettype wire

/* File: rmf_ctrl.sv */
// rmf_ctrl: mode word register, function gating and program defaults
// assumes: host writes arrive as one-cycle strobes already deserialised
// What this block does
// - clear programming words when processing leaves reset without keep bit.
// - load pattern defaults c4d7, b433 and full limiter on that reset.
// - low two mode bits pick idle, receive or transmit; 11 reserved.
// - receive searches every enabled signal type at once.
// - transmit signal starts as soon as its enable is written.
// - bits 4:3 pick modem rate; 11 monitors both in receive only.
// - modem transmit starts or stops at once when bits change.
// - bits 5,6,7 enable searches for pattern b, a, inverted a.
// - after pattern found all bits are data until 350 us gap.
// - bits 11:9 pick sub-audio; combinations only in receive.
// - tone generator bit 12; transmit only when 14,13,4,3 clear.
// - bits 14:13 pick selective call or dual tone; voice needed.
// - de-emphasis of in-band only with voice and programming bit set.
// - voice path bit 15; transmit suspends it for 3,4,12,13,14.
// - receive suspends voice while tone generator bit is set.
// - clearing an enable stops its decoder; re-enable restarts it.
// - detections reported only above threshold, with hysteresis.
// - sub-audio and voice bands processed; squelch types in parallel.
// - pattern detect suspends selective call until host re-enables.
// - processing held in reset while power processing bit is low.
`timescale 1ns/1ns
`default_nettype none
module rmf_ctrl
	import rmf_pkg::*;
#(
	parameter int unsigned GAP_CYCLES = GAP_CYC
)
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic wr_stb,
	input wire logic [7:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [15:0] pwr_ctrl,
	input wire logic prog_emph_bit,
	input wire logic pattern_found,
	input wire logic [2:0] sub_det,
	input wire logic voice_det,
	input wire logic selcall_det,
	output logic proc_reset,
	output logic prog_load,
	output logic [15:0] fpa_lo,
	output logic [15:0] fpa_hi,
	output logic [15:0] fpb_lo,
	output logic [15:0] fpb_hi,
	output logic [15:0] lim_level,
	output logic [15:0] mode_word,
	output logic rx_active,
	output logic tx_active,
	output logic [1:0] modem_run,
	output logic [2:0] pat_search,
	output logic [2:0] sub_run,
	output logic tone_run,
	output logic selcall_run,
	output logic dual_tone_signalling_run,
	output logic voice_run,
	output logic deemph_run,
	output logic [1:0] dec_restart,
	output logic data_phase,
	output logic [2:0] sub_report,
	output logic voice_report,
	output logic selcall_report
);
	rmf_en_if en ();
	logic [15:0] mode_r, mode_nxt;
	logic sp_r, sp_nxt;
	logic ld_r, ld_nxt;
	logic [15:0] fal_r, fal_nxt, fah_r, fah_nxt;
	logic [15:0] fbl_r, fbl_nxt, fbh_r, fbh_nxt, lim_r, lim_nxt;
	logic rx_r, rx_nxt, tx_r, tx_nxt;
	logic [1:0] mr_r, mr_nxt;
	logic [2:0] ps_r, ps_nxt, sr_r, sr_nxt;
	logic tn_r, tn_nxt, sc_r, sc_nxt, dt_r, dt_nxt;
	logic vo_r, vo_nxt, de_r, de_nxt;
	logic [1:0] rs_r, rs_nxt;
	logic dp_r, dp_nxt, sup_r, sup_nxt;
	logic [2:0] srep_r, srep_nxt;
	logic vrep_r, vrep_nxt, crep_r, crep_nxt;
	logic gap_hold, gap_done;
	logic other_band;

	rmf_decode u_dec (
		.mode(mode_r),
		.en(en)
	);

	// gap held while state or modem bits are zero
	assign gap_hold = (mode_r[ST_LO+:2] == 2'b00) ||
		(mode_r[MOD_LO+:2] == 2'b00);
	rmf_gap_timer #(.CYC(GAP_CYCLES)) u_gap (
		.core_clk(core_clk),
		.resetn(resetn),
		.hold(gap_hold),
		.done(gap_done)
	);

	// mode word: writable at any time, read back on the mode_word output
	always_comb
	begin
		mode_nxt = mode_r;
		if (wr_stb && wr_addr == MODE_ADDR)
			mode_nxt = wr_data;
	end

	// programming defaults on processing power-up edge
	always_comb
	begin
		sp_nxt = pwr_ctrl[PWR_SP_BIT];
		ld_nxt = pwr_ctrl[PWR_SP_BIT] && !sp_r && !pwr_ctrl[PWR_KEEP_BIT];
		fal_nxt = fal_r;
		fah_nxt = fah_r;
		fbl_nxt = fbl_r;
		fbh_nxt = fbh_r;
		lim_nxt = lim_r;
		if (ld_nxt)
		begin
			// other words clear through prog_load pulse
			fal_nxt = FPA_LO_DEF;
			fah_nxt = FPA_HI_DEF;
			fbl_nxt = FPB_LO_DEF;
			fbh_nxt = FPB_HI_DEF;
			lim_nxt = LIM_DEF;
		end
	end

	// gated function enables; all drop when processing is off, data phase and suspension hold
	always_comb
	begin
		other_band = en.tone || (en.inband != 2'b00) || (en.modem != 2'b00);
		rx_nxt = en.rx && sp_r;
		tx_nxt = en.tx && sp_r;
		// modem follows bits directly, reserved 11 ignored in transmit
		mr_nxt = 2'b00;
		if (rx_nxt)
			mr_nxt = en.modem;
		else if (tx_nxt && en.modem != 2'b11)
			mr_nxt = en.modem;
		ps_nxt = (rx_nxt && en.modem != 2'b00 && !dp_r) ? en.pat : 3'b000;
		sr_nxt = 3'b000;
		if (rx_nxt)
			sr_nxt = en.sub;
		else if (tx_nxt && $countones(en.sub) == 1)
			sr_nxt = en.sub;
		tn_nxt = (rx_nxt && en.tone) ||
			(tx_nxt && en.tone && en.inband == 2'b00 &&
			en.modem == 2'b00);
		// selective call runs unless a pattern hit suspended it
		sc_nxt = (rx_nxt || tx_nxt) && en.inband == 2'b01 &&
			!sup_r;
		dt_nxt = tx_nxt && en.inband == 2'b10;
		vo_nxt = en.voice && ((rx_nxt && !en.tone) ||
			(tx_nxt && !other_band));
		de_nxt = rx_nxt && en.voice && prog_emph_bit &&
			en.inband == 2'b01;
		rs_nxt = {en.inband == 2'b01 && !sc_r && sc_nxt,
			en.modem != 2'b00 && mr_r == 2'b00 && mr_nxt != 2'b00};
		// a hit in the gap's last cycle wins, so no frame is lost
		dp_nxt = dp_r;
		if (pattern_found && rx_r && mr_r != 2'b00)
			dp_nxt = 1'b1;
		else if (gap_done)
			dp_nxt = 1'b0;
		// suspension lifted when host moves the in-band bits off 01
		sup_nxt = sup_r;
		if (pattern_found && rx_r)
			sup_nxt = 1'b1;
		else if (en.inband != 2'b01)
			sup_nxt = 1'b0;
		// detectors already apply thresholds; only enabled ones report
		srep_nxt = sub_det & sr_r;
		vrep_nxt = voice_det && vo_r && rx_r;
		crep_nxt = selcall_det && sc_r && rx_r;
	end

	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			mode_r <= MODE_RST;
			sp_r <= 1'b0;
			ld_r <= 1'b0;
			fal_r <= PROG_CLR;
			fah_r <= PROG_CLR;
			fbl_r <= PROG_CLR;
			fbh_r <= PROG_CLR;
			lim_r <= PROG_CLR;
			rx_r <= 1'b0;
			tx_r <= 1'b0;
			mr_r <= 2'b00;
			ps_r <= 3'b000;
			sr_r <= 3'b000;
			tn_r <= 1'b0;
			sc_r <= 1'b0;
			dt_r <= 1'b0;
			vo_r <= 1'b0;
			de_r <= 1'b0;
			rs_r <= 2'b00;
			dp_r <= 1'b0;
			sup_r <= 1'b0;
			srep_r <= 3'b000;
			vrep_r <= 1'b0;
			crep_r <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			sp_r <= sp_nxt;
			ld_r <= ld_nxt;
			fal_r <= fal_nxt;
			fah_r <= fah_nxt;
			fbl_r <= fbl_nxt;
			fbh_r <= fbh_nxt;
			lim_r <= lim_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			mr_r <= mr_nxt;
			ps_r <= ps_nxt;
			sr_r <= sr_nxt;
			tn_r <= tn_nxt;
			sc_r <= sc_nxt;
			dt_r <= dt_nxt;
			vo_r <= vo_nxt;
			de_r <= de_nxt;
			rs_r <= rs_nxt;
			dp_r <= dp_nxt;
			sup_r <= sup_nxt;
			srep_r <= srep_nxt;
			vrep_r <= vrep_nxt;
			crep_r <= crep_nxt;
		end
	end

	// processing reset comes from the registered power bit
	always_comb
	begin
		proc_reset = !sp_r;
		prog_load = ld_r;
		fpa_lo = fal_r;
		fpa_hi = fah_r;
		fpb_lo = fbl_r;
		fpb_hi = fbh_r;
		lim_level = lim_r;
		mode_word = mode_r;
		rx_active = rx_r;
		tx_active = tx_r;
		modem_run = mr_r;
		pat_search = ps_r;
		sub_run = sr_r;
		tone_run = tn_r;
		selcall_run = sc_r;
		dual_tone_signalling_run = dt_r;
		voice_run = vo_r;
		deemph_run = de_r;
		dec_restart = rs_r;
		data_phase = dp_r;
		sub_report = srep_r;
		voice_report = vrep_r;
		selcall_report = crep_r;
	end

	// transmit voice suspended by other voice band users
	tx_voice_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		tx_r && (tn_r || sc_r || dt_r || mr_r != 2'b00) |-> !vo_r)
		else $error("voice runs with other tx band user");
	// defaults stand in the same cycle as the load pulse
	load_vals_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		$rose(ld_r) |-> fal_r == 16'h00d7 && fah_r == 16'h00c4 &&
		fbl_r == 16'h0033 && fbh_r == 16'h00b4 && lim_r == 16'h3fff)
		else $error("defaults not loaded");
	// processing off forces idle
	pwr_idle_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		!sp_r |=> !rx_r && !tx_r)
		else $error("active while processing held");
	// rx voice off while tone set
	rx_voice_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		rx_r && tn_r |-> !vo_r)
		else $error("rx voice with tone");
	// pattern hit suspends selective call two cycles later
	sel_susp_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		pattern_found && rx_r ##1 en.inband == 2'b01 |=> !sc_r)
		else $error("selcall not suspended");
	// tx tone only without other band users
	tx_tone_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		tx_r && tn_r |-> mr_r == 2'b00 && !sc_r && !dt_r)
		else $error("tx tone with other users");
	// mode write lands next cycle
	mode_wr_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		wr_stb && wr_addr == MODE_ADDR |=> mode_r == $past(wr_data))
		else $error("mode write lost");
	// search only while modem receive runs
	pat_gate_a: assert property (@(posedge core_clk)
		disable iff (!resetn)
		ps_r != 3'b000 |-> rx_r && mr_r != 2'b00)
		else $error("search without modem rx");
endmodule // rmf_ctrl
`default_nettype wire

/* File: rmf_host.sv */
// rmf_host: host side model, writes words to the mode control block
// assumes: the block samples wr_stb on the rising core_clk edge
`timescale 1ns/1ns
`default_nettype none
module rmf_host
(
	output logic wr_stb,
	output logic [7:0] wr_addr,
	output logic [15:0] wr_data,
	input wire logic core_clk
);
	// quiet bus at time zero
	initial
	begin
		wr_stb = 1'b0;
		wr_addr = 8'h00;
		wr_data = 16'h0000;
	end
	// one-cycle strobe; a released bus shows the inverse, never stale data
	task automatic write(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk);
		wr_stb = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge core_clk);
		wr_stb = 1'b0;
		wr_addr = ~a;
		wr_data = ~d;
	endtask
	// shapes a raw word into one this host may send
	function automatic logic [15:0] legal(input logic [15:0] r);
		logic [15:0] m;
		m = r & 16'hfefb; // bits 8 and 2 stay clear
		if (m[1:0] == 2'b11)
			m[1:0] = 2'b10;
		if (m[14:13] == 2'b11)
			m[14:13] = 2'b01;
		if (m[1:0] == 2'b00)
			m = 16'h0000; // idle carries no functions
		else if (m[1:0] == 2'b01)
		begin
			if (m[14:13] == 2'b10)
				m[14:13] = 2'b01;
			if (m[14:13] != 2'b00)
				m[15] = 1'b0;
		end
		else
		begin
			m[7:5] = 3'h0;
			if (m[4:3] != 2'b00)
				m[14:12] = 3'h0;
			if (m[14:13] != 2'b00)
				m[12] = 1'b0;
			if (m[14:12] != 3'h0)
				m[15] = 1'b1;
		end
		return m;
	endfunction
endmodule // rmf_host
`default_nettype wire

/* File: radio_mode_function_control_tb.sv */
// radio_mode_function_control_tb: mode decoding, gating and defaults
// assumes: rmf_ctrl as top, rmf_host as writer, 4 ns core clock
`timescale 1ns/1ns
`default_nettype none
module radio_mode_function_control_tb
	import rmf_pkg::*;
;
	localparam int GAP = 20;
	logic core_clk, resetn, wr_stb, prog_emph_bit, pattern_found;
	logic voice_det, selcall_det, proc_reset, prog_load, rx_active;
	logic tx_active, tone_run, selcall_run, dual_tone_signalling_run, voice_run;
	logic deemph_run, data_phase, voice_report, selcall_report;
	logic [7:0] wr_addr;
	logic [15:0] wr_data, pwr_ctrl, fpa_lo, fpa_hi, fpb_lo, fpb_hi;
	logic [15:0] lim_level, mode_word;
	logic [1:0] modem_run, dec_restart;
	logic [2:0] sub_det, pat_search, sub_run, sub_report;
	int n_fail, samples_checked, seed, k, mw;
	rmf_host host_u (.wr_stb(wr_stb), .wr_addr(wr_addr),
		.wr_data(wr_data), .core_clk(core_clk));
	rmf_ctrl #(.GAP_CYCLES(GAP)) dut_u (.core_clk(core_clk),
		.resetn(resetn), .wr_stb(wr_stb), .wr_addr(wr_addr),
		.wr_data(wr_data), .pwr_ctrl(pwr_ctrl),
		.prog_emph_bit(prog_emph_bit), .pattern_found(pattern_found),
		.sub_det(sub_det), .voice_det(voice_det),
		.selcall_det(selcall_det), .proc_reset(proc_reset),
		.prog_load(prog_load), .fpa_lo(fpa_lo), .fpa_hi(fpa_hi),
		.fpb_lo(fpb_lo), .fpb_hi(fpb_hi), .lim_level(lim_level),
		.mode_word(mode_word), .rx_active(rx_active),
		.tx_active(tx_active), .modem_run(modem_run),
		.pat_search(pat_search), .sub_run(sub_run), .tone_run(tone_run),
		.selcall_run(selcall_run), .dual_tone_signalling_run(dual_tone_signalling_run),
		.voice_run(voice_run), .deemph_run(deemph_run),
		.dec_restart(dec_restart), .data_phase(data_phase),
		.sub_report(sub_report), .voice_report(voice_report),
		.selcall_report(selcall_report));
	// free-running core clock
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// one counted comparison; an unknown never matches
	task automatic check(input string nm, input logic [15:0] seen,
		input int exp);
		samples_checked++;
		if (seen !== 16'(exp))
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, 16'(exp), seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// mode write, then let the three-stage answer land
	task automatic wr(input logic [15:0] m);
		host_u.write(MODE_ADDR, m);
		repeat (3) @(negedge core_clk);
	endtask
	// mode write counting decoder restart pulses while it lands
	task automatic wr_rst(input logic [15:0] m, input int sc, input int md);
		int a, b;
		a = 0;
		b = 0;
		host_u.write(MODE_ADDR, m);
		repeat (3)
		begin
			@(negedge core_clk);
			a += (dec_restart[1] === 1'b1);
			b += (dec_restart[0] === 1'b1);
		end
		check("selcall restart", 16'(a), sc);
		check("modem restart", 16'(b), md);
	endtask
	// power change, counting load pulses in a short window
	task automatic count_load(input logic [15:0] p, input int exp);
		int c;
		c = 0;
		pwr_ctrl = p;
		repeat (6)
		begin
			@(negedge core_clk);
			c += (prog_load === 1'b1);
		end
		check("prog_load count", 16'(c), exp);
	endtask
	// integer model of every gated enable for one legal word
	task automatic check_mode(input int m);
		int md, sb, tn, ib, v, rx, tx, s, vo, sc, de, vr, cr;
		md = (m >> 3) & 3;
		sb = (m >> 9) & 7;
		tn = (m >> 12) & 1;
		ib = (m >> 13) & 3;
		v = (m >> 15) & 1;
		rx = (m & 3) == 1;
		tx = (m & 3) == 2;
		s = rx || tx && sb inside {1, 2, 4} ? sb : 0;
		vo = v && !tn && (rx || !ib && !md);
		sc = (rx || tx) && ib == 1;
		de = rx && v && prog_emph_bit && ib == 1;
		vr = voice_det && vo && rx;
		cr = selcall_det && sc && rx;
		check("mode_word", mode_word, m);
		check("rx_active", rx_active, rx);
		check("tx_active", tx_active, tx);
		check("modem_run", modem_run, rx || tx && md != 3 ? md : 0);
		check("pat_search", pat_search, rx && md ? m >> 5 & 7 : 0);
		check("sub_run", sub_run, s);
		check("tone_run", tone_run, tn && (rx || !ib && !md));
		check("selcall_run", selcall_run, sc);
		check("dual_tone_signalling_run", dual_tone_signalling_run, tx && ib == 2);
		check("voice_run", voice_run, vo);
		check("deemph_run", deemph_run, de);
		check("sub_report", sub_report, sub_det & s);
		check("voice_report", voice_report, vr);
		check("selcall_report", selcall_report, cr);
	endtask
	// bounded wait for the frame hit to open the data phase
	task automatic wait_dp();
		for (int i = 0; i < 10 && data_phase !== 1'b1; i++)
			@(negedge core_clk);
		check("data_phase", data_phase, 1);
		if (data_phase !== 1'b1)
			give_verdict();
	endtask
	// main sequence
	initial
	begin
		seed = 15;
		n_fail = 0;
		samples_checked = 0;
		resetn = 1'b0;
		pwr_ctrl = 16'h0000;
		prog_emph_bit = 1'b0;
		pattern_found = 1'b0;
		sub_det = 3'h0;
		voice_det = 1'b0;
		selcall_det = 1'b0;
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		@(negedge core_clk);
		check("mode_word", mode_word, 0);
		check("proc_reset", proc_reset, 1);
		count_load(16'h0020, 1);
		check("fpa_lo", fpa_lo, 16'h00d7);
		check("fpa_hi", fpa_hi, 16'h00c4);
		check("fpb_lo", fpb_lo, 16'h0033);
		check("fpb_hi", fpb_hi, 16'h00b4);
		check("lim_level", lim_level, 16'h3fff);
		check("proc_reset", proc_reset, 0);
		count_load(16'h0010, 0);
		count_load(16'h0030, 0);
		// unmapped address must not reach the mode word
		host_u.write(8'hc0, 16'h0001);
		repeat (3) @(negedge core_clk);
		check("mode_word", mode_word, 0);
		// legal random words with random detector levels
		for (k = 0; k < 80; k++)
		begin
			sub_det = 3'($random(seed));
			{voice_det, selcall_det, prog_emph_bit} = 3'($random(seed));
			mw = int'(host_u.legal(16'($random(seed))));
			wr(16'(mw));
			check_mode(mw);
			check("mode_word", mode_word, mw);
		end
		// frame hit: data phase opens, selcall parked until the in-band bits leave 01
		wr(16'h20e9);
		check("selcall_run", selcall_run, 1);
		pattern_found = 1'b1;
		@(negedge core_clk);
		pattern_found = 1'b0;
		wait_dp();
		// suspension reaches the run flag two cycles after the hit
		@(negedge core_clk);
		check("selcall_run", selcall_run, 0);
		host_u.write(MODE_ADDR, 16'h20e1);
		repeat (GAP / 2) @(negedge core_clk);
		wr_rst(16'h20e9, 0, 1);
		check("data_phase", data_phase, 1);
		host_u.write(MODE_ADDR, 16'h20e1);
		repeat (GAP + 4) @(negedge core_clk);
		wr_rst(16'h20e9, 0, 1);
		check("data_phase", data_phase, 0);
		check("selcall_run", selcall_run, 0);
		wr(16'h00e9);
		wr_rst(16'h20e9, 1, 0);
		check("selcall_run", selcall_run, 1);
		// rx voice first, selcall after a shortened settle, de-emphasised
		prog_emph_bit = 1'b1;
		voice_det = 1'b1;
		selcall_det = 1'b1;
		wr(16'h8001);
		repeat (GAP) @(negedge core_clk);
		wr(16'ha001);
		check_mode(32'h0000_a001);
		// second reset in mid-run
		resetn = 1'b0;
		repeat (3) @(negedge core_clk);
		resetn = 1'b1;
		@(negedge core_clk);
		check("mode_word", mode_word, 0);
		check("rx_active", rx_active, 0);
		give_verdict();
	end
	// hang guard
	initial
	begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule // radio_mode_function_control_tb
`default_nettype wire
